// ==== operand_address_mode_decoder.sv ====
`timescale 1ns/1ps
`include "operand_addr_defs.svh"
module operand_address_mode_decoder import operand_addr_pkg::*; (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // Decode request
  input  wire logic         dec_start,
  input  wire addr_mode_t   dec_mode,
  input  wire logic         dec_rmw,
  input  wire logic         dec_use_y,
  input  wire logic [15:0]  pc_in,
  input  wire logic [7:0]   idx_x,
  input  wire logic [7:0]   idx_y,
  // Memory bus
  output logic              mem_req,
  output logic [15:0]       mem_addr,
  input  wire logic [7:0]   mem_rdata,
  input  wire logic         mem_ack,
  // Result
  output logic              dec_busy,
  output logic              dec_done,
  output logic              dec_err,
  output logic [15:0]       eff_addr,
  output logic [7:0]        imm_value,
  output logic [15:0]       branch_target,
  output logic [2:0]        instr_len,
  output mode_family_t      mode_family
);
  seq_state_t   state_q;
  addr_mode_t   mode_q;
  logic [15:0]  pc_q;
  logic [7:0]   index_q;
  logic [7:0]   code0_q;
  logic [7:0]   code1_q;
  logic [15:0]  ptr_q;
  logic [1:0]   cnt_q;
  logic         mem_req_q;
  logic [15:0]  mem_addr_q;
  logic         done_q;
  logic         err_q;
  logic [15:0]  ea_q;
  logic [7:0]   imm_q;
  logic [15:0]  target_q;
  logic [2:0]   len_q;
  mode_family_t fam_q;

  logic [1:0]   in_code, in_ptr, in_len, cur_code, cur_ptr, cur_len;
  logic         in_idx, in_rel, in_long, in_btj, cur_idx, cur_rel, cur_long, cur_btj;
  mode_family_t in_fam, cur_fam;
  logic [15:0]  base, pc_next, ea_sum, tgt_sum;
  logic [7:0]   rel_off, code0_now;
  logic         ack_take;

  mode_length_table u_req_tbl (
    .mode       (dec_mode),
    .code_bytes (in_code),
    .ptr_bytes  (in_ptr),
    .table_len  (in_len),
    .use_idx    (in_idx),
    .use_rel    (in_rel),
    .is_long    (in_long),
    .is_btj     (in_btj),
    .family     (in_fam)
  );

  mode_length_table u_cur_tbl (
    .mode       (mode_q),
    .code_bytes (cur_code),
    .ptr_bytes  (cur_ptr),
    .table_len  (cur_len),
    .use_idx    (cur_idx),
    .use_rel    (cur_rel),
    .is_long    (cur_long),
    .is_btj     (cur_btj),
    .family     (cur_fam)
  );

  function automatic logic [15:0] page_zero(input logic [7:0] b);
    page_zero = {`PAGE_ZERO_HI, b};
  endfunction

  assign ack_take  = mem_req_q && mem_ack;
  assign code0_now = (cnt_q == `CNT_ZERO) ? mem_rdata : code0_q;

  // Operand base: pointer, word from code, byte on page zero, or none
  always_comb begin
    if (cur_ptr != `CNT_ZERO)
      base = ptr_q;
    else if (cur_code == `CNT_TWO && !cur_btj)
      base = {code0_q, code1_q};
    else if (cur_code == `CNT_ZERO)
      base = `ADDR_ZERO;
    else
      base = page_zero(code0_q);
  end

  always_comb begin
    if (cur_btj)
      rel_off = code1_q;
    else if (cur_ptr != `CNT_ZERO)
      rel_off = ptr_q[7:0];
    else
      rel_off = code0_q;
  end

  assign pc_next = pc_q + `PC_STEP + {14'h0000, cur_code};

  ea_adder u_add (
    .base    (base),
    .index   (index_q),
    .use_idx (cur_idx),
    .ea      (ea_sum),
    .pc_next (pc_next),
    .rel_off (rel_off),
    .target  (tgt_sum)
  );

  // Sequencer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (dec_start && !(dec_rmw && in_long)) begin
            if (in_code != `CNT_ZERO)
              state_q <= S_CODE;
            else
              state_q <= S_CALC;
          end
        end
        S_CODE: begin
          if (ack_take && cnt_q + `CNT_ONE >= cur_code)
            state_q <= (cur_ptr != `CNT_ZERO) ? S_PTR : S_CALC;
        end
        S_PTR: begin
          if (ack_take && cnt_q + `CNT_ONE >= cur_ptr)
            state_q <= S_CALC;
        end
        S_CALC: state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Request capture
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_q  <= M_INH;
      pc_q    <= `ADDR_ZERO;
      index_q <= `BYTE_ZERO;
    end else if (state_q == S_IDLE && dec_start) begin
      mode_q  <= dec_mode;
      pc_q    <= pc_in;
      index_q <= dec_use_y ? idx_y : idx_x;
    end
  end

  // Byte counter and fetched bytes
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_q   <= `CNT_ZERO;
      code0_q <= `BYTE_ZERO;
      code1_q <= `BYTE_ZERO;
      ptr_q   <= `ADDR_ZERO;
    end else if (state_q == S_IDLE) begin
      cnt_q <= `CNT_ZERO;
      ptr_q <= `ADDR_ZERO;
    end else if (ack_take && state_q == S_CODE) begin
      if (cnt_q == `CNT_ZERO)
        code0_q <= mem_rdata;
      else
        code1_q <= mem_rdata;
      cnt_q <= (cnt_q + `CNT_ONE >= cur_code) ? `CNT_ZERO : cnt_q + `CNT_ONE;
    end else if (ack_take && state_q == S_PTR) begin
      ptr_q <= {ptr_q[7:0], mem_rdata};
      cnt_q <= cnt_q + `CNT_ONE;
    end
  end

  // Memory request and address
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mem_req_q  <= 1'b0;
      mem_addr_q <= `ADDR_ZERO;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (dec_start && !(dec_rmw && in_long) && in_code != `CNT_ZERO) begin
            mem_req_q  <= 1'b1;
            mem_addr_q <= pc_in + `PC_STEP;
          end
        end
        S_CODE: begin
          if (ack_take) begin
            if (cnt_q + `CNT_ONE < cur_code) begin
              mem_addr_q <= mem_addr_q + `PC_STEP;
            end else if (cur_ptr != `CNT_ZERO) begin
              mem_addr_q <= page_zero(code0_now);
            end else begin
              mem_req_q <= 1'b0;
            end
          end
        end
        S_PTR: begin
          if (ack_take) begin
            if (cnt_q + `CNT_ONE < cur_ptr)
              mem_addr_q <= mem_addr_q + `PC_STEP;
            else
              mem_req_q <= 1'b0;
          end
        end
        default: mem_req_q <= 1'b0;
      endcase
    end
  end

  // Results
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      done_q   <= 1'b0;
      err_q    <= 1'b0;
      ea_q     <= `ADDR_ZERO;
      imm_q    <= `BYTE_ZERO;
      target_q <= `ADDR_ZERO;
      len_q    <= `OPCODE_LEN;
      fam_q    <= F_INHERENT;
    end else begin
      done_q <= (state_q == S_CALC);
      err_q  <= (state_q == S_IDLE) && dec_start && dec_rmw && in_long;
      if (state_q == S_CALC) begin
        ea_q     <= ea_sum;
        imm_q    <= code0_q;
        target_q <= cur_rel ? tgt_sum : pc_next;
        len_q    <= `OPCODE_LEN + {1'b0, cur_len};
        fam_q    <= cur_fam;
      end
    end
  end

  assign mem_req       = mem_req_q;
  assign mem_addr      = mem_addr_q;
  assign dec_busy      = (state_q != S_IDLE);
  assign dec_done      = done_q;
  assign dec_err       = err_q;
  assign eff_addr      = ea_q;
  assign imm_value     = imm_q;
  assign branch_target = target_q;
  assign instr_len     = len_q;
  assign mode_family   = fam_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_start_inh;
    state_q == S_IDLE && dec_start && dec_mode == M_INH;
  endsequence
  sequence s_no_fetch_then_done;
    !mem_req_q ##1 done_q;
  endsequence
  sequence s_start_dirl;
    state_q == S_IDLE && dec_start && dec_mode == M_DIR_L && !dec_rmw;
  endsequence

  property p_inh_no_fetch;
    s_start_inh |=> s_no_fetch_then_done;
  endproperty
  a_inh_no_fetch: assert property (p_inh_no_fetch)
    else $error("inherent mode fetched or did not finish in two cycles");

  property p_dirl_fetch;
    s_start_dirl |=> mem_req_q && mem_addr_q == $past(pc_in) + `PC_STEP;
  endproperty
  a_dirl_fetch: assert property (p_dirl_fetch)
    else $error("long direct did not fetch the byte after the opcode");

  property p_rmw_long;
    state_q == S_IDLE && dec_start && dec_rmw && in_long |=> err_q && !mem_req_q ##1 !done_q;
  endproperty
  a_rmw_long: assert property (p_rmw_long)
    else $error("long mode accepted for read-modify-write");

  property p_short_page_zero;
    done_q && (mode_q == M_DIR_S || mode_q == M_IND_S || mode_q == M_BIT_D)
      |-> ea_q[15:8] == `PAGE_ZERO_HI;
  endproperty
  a_short_page_zero: assert property (p_short_page_zero)
    else $error("short mode address left page zero");

  property p_idx_short;
    done_q && mode_q == M_IDX_S |-> ea_q == page_zero(code0_q) + page_zero(index_q) &&
      ea_q <= `IDX_SHORT_MAX;
  endproperty
  a_idx_short: assert property (p_idx_short)
    else $error("short indexed sum wrong or wrapped");

  property p_idx0;
    done_q && mode_q == M_IDX_0 |-> ea_q == page_zero(index_q) && len_q == `OPCODE_LEN;
  endproperty
  a_idx0: assert property (p_idx0)
    else $error("indexed without offset address wrong");

  property p_idx_long;
    done_q && mode_q == M_IDX_L |-> ea_q == {code0_q, code1_q} + page_zero(index_q);
  endproperty
  a_idx_long: assert property (p_idx_long)
    else $error("long indexed sum wrong");

  property p_ptr_page_zero;
    state_q == S_PTR && mem_req_q |-> mem_addr_q[15:8] == `PAGE_ZERO_HI;
  endproperty
  a_ptr_page_zero: assert property (p_ptr_page_zero)
    else $error("pointer read outside page zero");

  property p_iix_long;
    done_q && mode_q == M_IIX_L |-> ea_q == ptr_q + page_zero(index_q);
  endproperty
  a_iix_long: assert property (p_iix_long)
    else $error("indirect indexed sum wrong");

  property p_rel_direct;
    done_q && mode_q == M_REL_D |->
      target_q == pc_q + `PC_STEP + `PC_STEP + {{8{code0_q[7]}}, code0_q};
  endproperty
  a_rel_direct: assert property (p_rel_direct)
    else $error("relative target wrong");

  property p_long_len;
    done_q && mode_q == M_DIR_L |-> len_q == `OPCODE_LEN + 3'h2 && fam_q == F_DIRECT;
  endproperty
  a_long_len: assert property (p_long_len)
    else $error("long direct length or family wrong");
endmodule // operand_address_mode_decoder

// ==== operand_addr_defs.svh ====
// Behaviour
// - Seventeen addressing modes in seven families
// - Short modes without an index reach page zero only
// - Long modes reach the whole 64 KB
// - Read-modify-write refuses long addressing modes
// - Inherent: one byte, nothing fetched after
// - Immediate: one operand value byte follows
// - Short direct: one address byte, 00-FF
// - Long direct: two address bytes follow
// - Indexed address is unsigned index plus offset
// - Indexed no offset: index alone, no bytes
// - Short indexed: byte offset, up to 1FE
// - Long indexed: word offset plus index
// - Indirect: pointer read before operand access
// - Short indirect: byte pointer from page zero
// - Long indirect: word pointer from page zero
// - Indirect indexed: pointer plus index register
// - Relative: PC plus signed 8-bit offset
`ifndef OPERAND_ADDR_DEFS_SVH
`define OPERAND_ADDR_DEFS_SVH
`define PAGE_ZERO_HI   8'h00
`define IDX_SHORT_MAX  16'h01fe
`define PC_STEP        16'h0001
`define ADDR_ZERO      16'h0000
`define BYTE_ZERO      8'h00
`define CNT_ZERO       2'h0
`define CNT_ONE        2'h1
`define CNT_TWO        2'h2
`define OPCODE_LEN     3'h1
`endif

// ==== operand_addr_pkg.sv ====
package operand_addr_pkg;
  typedef enum logic [4:0] {
    M_INH, M_IMM, M_DIR_S, M_DIR_L, M_IDX_0, M_IDX_S, M_IDX_L,
    M_IND_S, M_IND_L, M_IIX_S, M_IIX_L, M_REL_D, M_REL_I,
    M_BIT_D, M_BIT_I, M_BTJ_D, M_BTJ_I
  } addr_mode_t;
  typedef enum logic [2:0] {
    F_INHERENT, F_IMMEDIATE, F_DIRECT, F_INDEXED, F_INDIRECT, F_RELATIVE, F_BIT
  } mode_family_t;
  typedef enum logic [1:0] {S_IDLE, S_CODE, S_PTR, S_CALC} seq_state_t;
endpackage

// ==== mode_length_table.sv ====
`timescale 1ns/1ps
`include "operand_addr_defs.svh"
module mode_length_table import operand_addr_pkg::*; (
  // Mode in
  input  wire addr_mode_t   mode,
  // Decoded shape
  output logic [1:0]        code_bytes,
  output logic [1:0]        ptr_bytes,
  output logic [1:0]        table_len,
  output logic              use_idx,
  output logic              use_rel,
  output logic              is_long,
  output logic              is_btj,
  output mode_family_t      family
);
  always_comb begin
    code_bytes = `CNT_ZERO;
    ptr_bytes  = `CNT_ZERO;
    table_len  = `CNT_ZERO;
    use_idx    = 1'b0;
    use_rel    = 1'b0;
    is_long    = 1'b0;
    is_btj     = 1'b0;
    family     = F_INHERENT;
    case (mode)
      M_INH: begin
        family = F_INHERENT;
      end
      M_IMM: begin
        code_bytes = `CNT_ONE; table_len = 2'h1; family = F_IMMEDIATE;
      end
      M_DIR_S: begin
        code_bytes = `CNT_ONE; table_len = 2'h1; family = F_DIRECT;
      end
      M_DIR_L: begin
        code_bytes = `CNT_TWO; table_len = 2'h2; is_long = 1'b1; family = F_DIRECT;
      end
      M_IDX_0: begin
        use_idx = 1'b1; family = F_INDEXED;
      end
      M_IDX_S: begin
        code_bytes = `CNT_ONE; table_len = 2'h1; use_idx = 1'b1; family = F_INDEXED;
      end
      M_IDX_L: begin
        code_bytes = `CNT_TWO; table_len = 2'h2; use_idx = 1'b1; is_long = 1'b1;
        family = F_INDEXED;
      end
      M_IND_S: begin
        code_bytes = `CNT_ONE; ptr_bytes = `CNT_ONE; table_len = 2'h2; family = F_INDIRECT;
      end
      M_IND_L: begin
        code_bytes = `CNT_ONE; ptr_bytes = `CNT_TWO; table_len = 2'h2; is_long = 1'b1;
        family = F_INDIRECT;
      end
      M_IIX_S: begin
        code_bytes = `CNT_ONE; ptr_bytes = `CNT_ONE; table_len = 2'h2; use_idx = 1'b1;
        family = F_INDIRECT;
      end
      M_IIX_L: begin
        code_bytes = `CNT_ONE; ptr_bytes = `CNT_TWO; table_len = 2'h2; use_idx = 1'b1;
        is_long = 1'b1; family = F_INDIRECT;
      end
      M_REL_D: begin
        code_bytes = `CNT_ONE; table_len = 2'h1; use_rel = 1'b1; family = F_RELATIVE;
      end
      M_REL_I: begin
        code_bytes = `CNT_ONE; ptr_bytes = `CNT_ONE; table_len = 2'h2; use_rel = 1'b1;
        family = F_RELATIVE;
      end
      M_BIT_D: begin
        code_bytes = `CNT_ONE; table_len = 2'h1; family = F_BIT;
      end
      M_BIT_I: begin
        code_bytes = `CNT_ONE; ptr_bytes = `CNT_ONE; table_len = 2'h2; family = F_BIT;
      end
      M_BTJ_D: begin
        code_bytes = `CNT_TWO; table_len = 2'h2; use_rel = 1'b1; is_btj = 1'b1;
        family = F_BIT;
      end
      M_BTJ_I: begin
        code_bytes = `CNT_TWO; ptr_bytes = `CNT_ONE; table_len = 2'h3; use_rel = 1'b1;
        is_btj = 1'b1; family = F_BIT;
      end
      default: begin
        family = F_INHERENT;
      end
    endcase
  end
endmodule // mode_length_table

// ==== ea_adder.sv ====
`timescale 1ns/1ps
`include "operand_addr_defs.svh"
module ea_adder (
  // Address sum
  input  wire logic [15:0] base,
  input  wire logic [7:0]  index,
  input  wire logic        use_idx,
  output logic [15:0]      ea,
  // Branch sum
  input  wire logic [15:0] pc_next,
  input  wire logic [7:0]  rel_off,
  output logic [15:0]      target
);
  // Full 16-bit unsigned sum, so a short offset carries into bit 8
  assign ea     = use_idx ? base + {`PAGE_ZERO_HI, index} : base;
  assign target = pc_next + {{8{rel_off[7]}}, rel_off};
endmodule // ea_adder

// ==== mem_partner.sv ====
`timescale 1ns/1ps
module mem_partner (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Byte read bus
  input  wire logic        mem_req,
  input  wire logic [15:0] mem_addr,
  output logic [7:0]       mem_rdata,
  output logic             mem_ack,
  // Wait cycles before each answer
  input  wire logic [3:0]  stall
);
  logic [7:0] store [logic [15:0]];
  logic [3:0] wait_q;

  initial begin
    mem_rdata = 8'h00;
    mem_ack   = 1'b0;
    wait_q    = 4'h0;
  end

  // One byte per request; data is not held once the answer is gone
  always @(posedge clk_sys) begin
    #1;
    if (!rst_n || mem_ack || !mem_req) begin
      mem_ack   = 1'b0;
      wait_q    = 4'h0;
      mem_rdata = ~mem_rdata;
    end else if (wait_q >= stall) begin
      mem_ack   = 1'b1;
      mem_rdata = store.exists(mem_addr) ? store[mem_addr] : ~mem_addr[7:0];
    end else begin
      wait_q    = wait_q + 4'h1;
      mem_rdata = ~mem_rdata;
    end
  end
endmodule // mem_partner

// ==== test_operand_address_mode_decoder.sv ====
`timescale 1ns/1ps
module test_operand_address_mode_decoder import operand_addr_pkg::*;;
  typedef struct {
    addr_mode_t   m;
    logic         y;
    logic [15:0]  ea;
    logic [15:0]  tg;
    logic [2:0]   len;
    logic [2:0]   nf;
    mode_family_t fam;
    logic         ce;
    logic         cf;
  } row_t;

  logic         clk_sys;
  logic         rst_n;
  logic         dec_start;
  addr_mode_t   dec_mode;
  logic         dec_rmw;
  logic         dec_use_y;
  logic [15:0]  pc_in;
  logic [7:0]   idx_x;
  logic [7:0]   idx_y;
  logic         mem_req;
  logic [15:0]  mem_addr;
  logic [7:0]   mem_rdata;
  logic         mem_ack;
  logic         dec_busy;
  logic         dec_done;
  logic         dec_err;
  logic [15:0]  eff_addr;
  logic [7:0]   imm_value;
  logic [15:0]  branch_target;
  logic [2:0]   instr_len;
  mode_family_t mode_family;
  logic [3:0]   stall;
  int           n_errors;
  int           compares;
  int           n_fetch;
  row_t         rows [0:16];

  operand_address_mode_decoder dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .dec_start(dec_start), .dec_mode(dec_mode),
    .dec_rmw(dec_rmw), .dec_use_y(dec_use_y), .pc_in(pc_in), .idx_x(idx_x),
    .idx_y(idx_y), .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .dec_busy(dec_busy), .dec_done(dec_done), .dec_err(dec_err),
    .eff_addr(eff_addr), .imm_value(imm_value), .branch_target(branch_target),
    .instr_len(instr_len), .mode_family(mode_family)
  );

  mem_partner mem (
    .clk_sys(clk_sys), .rst_n(rst_n), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .stall(stall)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Count completed byte reads
  always @(posedge clk_sys) begin
    if (mem_req === 1'b1 && mem_ack === 1'b1) begin
      n_fetch++;
    end
  end

  task automatic wrap_up();
    $display("counts: %0d compares, %0d mismatches", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(logic [15:0] got, logic [15:0] exp, string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic issue(addr_mode_t m, logic y, logic rmw);
    dec_mode  = m;
    dec_use_y = y;
    dec_rmw   = rmw;
    dec_start = 1'b1;
    n_fetch   = 0;
    @(posedge clk_sys);
    #1;
    dec_start = 1'b0;
  endtask

  task automatic finish_dec(output logic got_done, output logic got_err);
    int i;
    for (i = 0; i < 200; i++) begin
      if (dec_done === 1'b1 || dec_err === 1'b1) break;
      @(posedge clk_sys);
      #1;
    end
    got_done = dec_done;
    got_err  = dec_err;
    if (i == 200) begin
      n_errors++;
      $display("MISMATCH %0t no answer from decoder", $time);
      wrap_up();
    end
  endtask

  initial begin
    logic d;
    logic e;
    addr_mode_t longs [4];
    rst_n = 1'b0;
    dec_start = 1'b0;
    dec_mode = M_INH;
    dec_rmw = 1'b0;
    dec_use_y = 1'b0;
    pc_in = 16'h1000;
    idx_x = 8'hff;
    idx_y = 8'h11;
    stall = 4'h0;
    n_errors = 0;
    compares = 0;
    n_fetch = 0;
    longs = '{M_DIR_L, M_IDX_L, M_IND_L, M_IIX_L};
    mem.store[16'h1001] = 8'h80;
    mem.store[16'h1002] = 8'h34;
    mem.store[16'h0080] = 8'hc2;
    mem.store[16'h0081] = 8'h9a;
    rows = '{
      '{M_INH,   0, 16'h0000, 16'h1001, 3'h1, 3'h0, F_INHERENT,  0, 1},
      '{M_IMM,   0, 16'h0000, 16'h1002, 3'h2, 3'h1, F_IMMEDIATE, 0, 1},
      '{M_DIR_S, 0, 16'h0080, 16'h1002, 3'h2, 3'h1, F_DIRECT,    1, 1},
      '{M_DIR_L, 0, 16'h8034, 16'h1003, 3'h3, 3'h2, F_DIRECT,    1, 1},
      '{M_IDX_0, 0, 16'h00ff, 16'h1001, 3'h1, 3'h0, F_INDEXED,   1, 1},
      '{M_IDX_S, 0, 16'h017f, 16'h1002, 3'h2, 3'h1, F_INDEXED,   1, 1},
      '{M_IDX_L, 1, 16'h8045, 16'h1003, 3'h3, 3'h2, F_INDEXED,   1, 1},
      '{M_IND_S, 0, 16'h00c2, 16'h1002, 3'h3, 3'h2, F_INDIRECT,  1, 1},
      '{M_IND_L, 0, 16'hc29a, 16'h1002, 3'h3, 3'h3, F_INDIRECT,  1, 1},
      '{M_IIX_S, 0, 16'h01c1, 16'h1002, 3'h3, 3'h2, F_INDIRECT,  1, 0},
      '{M_IIX_L, 1, 16'hc2ab, 16'h1002, 3'h3, 3'h3, F_INDIRECT,  1, 0},
      '{M_REL_D, 0, 16'h0000, 16'h0f82, 3'h2, 3'h1, F_RELATIVE,  0, 1},
      '{M_REL_I, 0, 16'h0000, 16'h0fc4, 3'h3, 3'h2, F_RELATIVE,  0, 1},
      '{M_BIT_D, 0, 16'h0080, 16'h1002, 3'h2, 3'h1, F_BIT,       1, 1},
      '{M_BIT_I, 0, 16'h00c2, 16'h1002, 3'h3, 3'h2, F_BIT,       1, 1},
      '{M_BTJ_D, 0, 16'h0080, 16'h1037, 3'h3, 3'h2, F_BIT,       1, 1},
      '{M_BTJ_I, 0, 16'h00c2, 16'h1037, 3'h4, 3'h3, F_BIT,       1, 1}
    };
    repeat (6) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    // Reset values
    chk(dec_busy, 1'b0, "busy after reset");
    chk(mem_req, 1'b0, "request after reset");
    chk(instr_len, 3'h1, "length after reset");
    chk(eff_addr, 16'h0000, "address after reset");
    $display("test reset_values done");
    // All modes, prompt memory then slow memory
    for (int s = 0; s < 2; s++) begin
      stall = (s == 0) ? 4'h0 : 4'h2;
      for (int r = 0; r < 17; r++) begin
        issue(rows[r].m, rows[r].y, 1'b0);
        finish_dec(d, e);
        chk(d, 1'b1, rows[r].m.name());
        chk(n_fetch, rows[r].nf, "byte reads");
        chk(instr_len, rows[r].len, "length");
        chk(branch_target, rows[r].tg, "branch target");
        if (rows[r].ce) chk(eff_addr, rows[r].ea, "address");
        if (rows[r].cf) chk(mode_family, rows[r].fam, "family");
        if (rows[r].m == M_IMM) chk(imm_value, 8'h80, "immediate");
        @(posedge clk_sys);
        #1;
      end
      $display("test mode_table stall %0d done", stall);
    end
    // Read-modify-write with long modes is refused without fetching
    for (int k = 0; k < 4; k++) begin
      issue(longs[k], 1'b0, 1'b1);
      finish_dec(d, e);
      chk(e, 1'b1, "refusal");
      chk(d, 1'b0, "done on refusal");
      chk(n_fetch, 0, "reads on refusal");
      @(posedge clk_sys);
      #1;
      chk(dec_err, 1'b0, "refusal pulse width");
    end
    issue(M_DIR_S, 1'b0, 1'b1);
    finish_dec(d, e);
    chk(d, 1'b1, "short modify accepted");
    chk(eff_addr, 16'h0080, "short modify address");
    $display("test modify_refusal done");
    // Back to back with slow memory: next request on the done edge
    stall = 4'h3;
    @(posedge clk_sys);
    #1;
    issue(M_DIR_L, 1'b0, 1'b0);
    finish_dec(d, e);
    chk(eff_addr, 16'h8034, "first of pair");
    issue(M_IDX_S, 1'b0, 1'b0);
    chk(dec_busy, 1'b1, "second taken");
    finish_dec(d, e);
    chk(eff_addr, 16'h017f, "second of pair");
    $display("test back_to_back done");
    // Reset in mid-decode, then a clean decode
    issue(M_IND_L, 1'b0, 1'b0);
    repeat (3) @(posedge clk_sys);
    #1;
    rst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(dec_busy, 1'b0, "busy in reset");
    chk(mem_req, 1'b0, "request in reset");
    rst_n = 1'b1;
    stall = 4'h0;
    issue(M_IND_S, 1'b0, 1'b0);
    finish_dec(d, e);
    chk(eff_addr, 16'h00c2, "address after reset");
    $display("test mid_reset done");
    wrap_up();
  end
endmodule // test_operand_address_mode_decoder
